// ==== dv/mcis_core_chk.sv ====
// port checker for the core instruction subset
`include "mcis_params.svh"
module mcis_core_chk (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // core ports
    input wire logic [13:0] instr_i,
    input wire logic [12:0] pc_o,
    input wire logic        vpp_high_i,
    input wire logic        prog_clk_pin_i,
    input wire logic        prog_dat_pin_i,
    input wire logic        prog_dat_oe_n_o,
    input wire logic [7:0]  acc_o,
    input wire logic [7:0]  status_o,
    input wire logic        prog_mode_o
);
    logic       nok_d, nok_q, ex;
    logic [8:0] sum;
    // a slot after call or bit test may be discarded, so it is not judged
    always_comb begin
        nok_d = instr_i[13:11] == `MCIS_OP3_CALL || instr_i[13:10] == `MCIS_OP4_BTSS;
    end
    always_ff @(posedge clk_i) begin
        nok_q <= rst_i ? 1'b0 : nok_d;
    end
    assign ex  = !nok_q && !prog_mode_o;
    assign sum = {1'b0, acc_o} + {1'b0, instr_i[7:0]};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_call;
        ex && instr_i[13:11] == `MCIS_OP3_CALL;
    endsequence
    sequence s_skip;
        ex && instr_i[13:10] == `MCIS_OP4_BTSS && instr_i[6:0] == `MCIS_ADR_STATUS
            && status_o[instr_i[9:7]];
    endsequence
    AST_ADDLIT: assert property (ex && instr_i[13:9] == 5'h1F
        |=> acc_o == $past(sum[7:0]) && status_o[0] == $past(sum[8])) else $error("add lit");
    AST_ANDLIT: assert property (ex && instr_i[13:8] == `MCIS_OP6_ANDLIT
        |=> acc_o == ($past(acc_o) & $past(instr_i[7:0])) && status_o[1:0] == $past(status_o[1:0])
        && status_o[2] == (acc_o == 8'h00)) else $error("and lit");
    AST_ADDREG: assert property (ex && instr_i == {`MCIS_OP6_ADDREG, 8'h03}
        |=> acc_o == 8'($past(acc_o) + $past(status_o))) else $error("add reg");
    AST_CLRSTAT: assert property (ex && instr_i == {`MCIS_OP6_CLR, 8'h83}
        |=> status_o == 8'h04) else $error("clear status");
    AST_CLRACC: assert property (ex && instr_i == `MCIS_CLR_ACC
        |=> acc_o == 8'h00 && status_o[2]) else $error("clear acc");
    AST_CALLPC: assert property (s_call |=> pc_o[10:0] == $past(instr_i[10:0]))
        else $error("call target");
    AST_CALLKILL: assert property (s_call ##1 1'b1 |=> $stable(acc_o) && $stable(status_o))
        else $error("call slot");
    AST_SKIP: assert property (s_skip ##1 1'b1 |=> $stable(acc_o) && $stable(status_o))
        else $error("skip slot");
    AST_ENTRY: assert property ($rose(vpp_high_i) && !prog_clk_pin_i && !prog_dat_pin_i
        |-> ##[1:8] prog_mode_o) else $error("no entry");
    AST_PCZERO: assert property ($rose(prog_mode_o) |-> ##[0:2] pc_o == `MCIS_RESET_PC)
        else $error("pc not zero");
    // the data driver lets go one edge after the mode drops
    AST_IDLEDRV: assert property (!prog_mode_o ##1 !prog_mode_o |-> prog_dat_oe_n_o)
        else $error("drive outside mode");
endmodule : mcis_core_chk
bind mcis_core mcis_core_chk chk_inst (
    .clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i), .pc_o(pc_o), .acc_o(acc_o),
    .vpp_high_i(vpp_high_i), .prog_clk_pin_i(prog_clk_pin_i), .status_o(status_o),
    .prog_dat_pin_i(prog_dat_pin_i), .prog_dat_oe_n_o(prog_dat_oe_n_o),
    .prog_mode_o(prog_mode_o)
);

// ==== dv/mcis_prog_model.sv ====
// serial programmer model on the program/verify pins
module mcis_prog_model (
    // clock
    input  wire logic clk_i,
    // device data output
    input  wire logic dev_dat_i,
    input  wire logic dev_oe_n_i,
    // pins
    output logic      vpp_o,
    output logic      pclk_o,
    output logic      pdat_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv_q = 1'b1;
    logic bit_q = 1'b0;
    logic idle_q = 1'b0;
    logic vpp_q = 1'b0;
    logic pclk_q = 1'b0;
    assign vpp_o = vpp_q;
    assign pclk_o = pclk_q;
    // a released line toggles so a stale bit cannot pass as read data
    always @(posedge clk_i) idle_q <= !idle_q;
    assign pdat_o = !dev_oe_n_i ? dev_dat_i : (drv_q ? bit_q : idle_q);
    task automatic enter();
        @(posedge clk_i);
        vpp_q <= 1'b1;
    endtask : enter
    task automatic put(input logic b);
        @(posedge clk_i);
        bit_q <= b;
        repeat (4) @(posedge clk_i);
        pclk_q <= 1'b1;
        repeat (4) @(posedge clk_i);
        pclk_q <= 1'b0;
    endtask : put
    task automatic cmd(input logic [5:0] c);
        for (int i = 0; i < 6; i++) begin
            put(c[i]);
        end
    endtask : cmd
    task automatic load(input logic [13:0] d);
        for (int i = 0; i < 14; i++) begin
            put(d[i]);
        end
    endtask : load
    task automatic recv(output logic [13:0] v);
        for (int i = 0; i < 14; i++) begin
            @(posedge clk_i);
            drv_q <= 1'b0;
            // each bit stands before the clock rise that advances it
            repeat (4) @(posedge clk_i);
            v[i] = pdat_o;
            pclk_q <= 1'b1;
            repeat (4) @(posedge clk_i);
            pclk_q <= 1'b0;
        end
        drv_q <= 1'b1;
    endtask : recv
endmodule : mcis_prog_model

// ==== dv/tb_mcis_core.sv ====
// self-checking bench for the core instruction subset
`include "mcis_params.svh"
module tb_mcis_core;
    timeunit 1ns;
    timeprecision 1ps;
    // =====
    // signals
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [13:0] instr_i = 14'h0000;
    logic        vpp, pclk, dat_o, oe_n, mode_o;
    wire logic   pdat;
    logic [12:0] pc_o;
    logic [7:0]  acc_o, st_o;
    logic [13:0] rd;
    int          n_fail = 0, total_checks = 0, cyc = 0;
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    mcis_prog_model prog_inst (.clk_i(clk_i), .dev_dat_i(dat_o), .dev_oe_n_i(oe_n),
        .vpp_o(vpp), .pclk_o(pclk), .pdat_o(pdat));
    mcis_core mcis_core_inst (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i), .pc_o(pc_o),
        .vpp_high_i(vpp), .prog_clk_pin_i(pclk), .prog_dat_pin_i(pdat), .prog_dat_o(dat_o),
        .prog_dat_oe_n_o(oe_n), .acc_o(acc_o), .status_o(st_o), .prog_mode_o(mode_o));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("checks=%0d fails=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    // back to back words, then a no-op while results settle
    task automatic run(input logic [13:0] q[$]);
        @(posedge clk_i);
        foreach (q[i]) begin
            instr_i <= q[i];
            @(posedge clk_i);
        end
        instr_i <= 14'h0000;
        #1;
    endtask : run
    task automatic t_lit();
        run('{14'h0103});
        check(16'(acc_o), 16'h0000);
        check(16'(st_o), 16'h0004);
        run('{14'h3E15});
        check(16'(acc_o), 16'h0015);
        run('{14'h3EF0, 14'h3E0B});
        check(16'(acc_o), 16'h0010);
        check(16'(st_o), 16'h0002);
        run('{14'h390F});
        check(16'(st_o), 16'h0006);
    endtask : t_lit
    task automatic t_file();
        run('{14'h3E07, 14'h0183, 14'h0583});
        check(16'(acc_o), 16'h0007);
        check(16'(st_o), 16'h0000);
        run('{14'h0183});
        check(16'(st_o), 16'h0004);
        run('{14'h0783});
        check(16'(st_o), 16'h0008);
        run('{14'h0103, 14'h0703, 14'h0503});
        check(16'(acc_o), 16'h0008);
        run('{14'h0185, 14'h0103, 14'h0705});
        check(16'(acc_o), 16'h0008);
    endtask : t_file
    task automatic t_skip();
        run('{14'h0103, 14'h1D03, 14'h3E01});
        check(16'(acc_o), 16'h0000);
        run('{14'h1C03, 14'h3E01});
        check(16'(acc_o), 16'h0001);
    endtask : t_skip
    task automatic t_call();
        run('{14'h0103, 14'h3E18, 14'h018A, 14'h078A, 14'h27FF});
        check(16'(pc_o), 16'h1FFF);
        run('{14'h2123, 14'h3E01});
        check(16'(acc_o), 16'h0018);
        run('{14'h0182});
        check(16'(pc_o), 16'h1800);
    endtask : t_call
    task automatic t_prog();
        prog_inst.enter();
        for (int i = 0; i < 20 && mode_o !== 1'b1; i++) begin
            @(posedge clk_i);
        end
        // the zero pc is launched one edge after the mode flag
        @(posedge clk_i);
        #1;
        check(16'(mode_o), 16'h0001);
        check(16'(pc_o), 16'h0000);
        prog_inst.cmd(`MCIS_CMD_LOAD);
        prog_inst.load(14'h1A5C);
        prog_inst.cmd(`MCIS_CMD_READ);
        prog_inst.recv(rd);
        check(16'(rd), 16'h1A5C);
    endtask : t_prog
    // hang guard, well above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_lit();
        t_file();
        t_skip();
        t_call();
        t_prog();
        results();
    end
endmodule : tb_mcis_core

// ==== rtl/mcis_core.sv ====
// core instruction subset: decode, execute and program/verify entry
// Function
// - literal add sets carry, half carry, zero
// - literal and updates zero only
// - register add sets carry, half carry, zero
// - destination bit picks accumulator or register
// - register and, routed, zero only
// - bit set skips next, two cycles
// - call pushes pc plus one, two cycles
// - call loads k and latch bits
// - clear register writes zero, sets zero
// - flag updates override written status bits
// - direction bit three always reads one
// - low pc read and write semantics
// - both pins low as high voltage rises enters programming
// - programming mode starts pc at zero
// - six bit command, fourteen data bits
// - id words only in programming mode
`include "mcis_params.svh"
module mcis_core
    import mcis_pkg::*;
#(
    parameter int STACK_DEPTH = 8,
    parameter int PROG_WORDS  = 1024
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // instruction fetch
    input  wire logic [13:0] instr_i,
    output logic [12:0]      pc_o,
    // pins
    input  wire logic        vpp_high_i,
    input  wire logic        prog_clk_pin_i,
    input  wire logic        prog_dat_pin_i,
    output logic             prog_dat_o,
    output logic             prog_dat_oe_n_o,
    // state view
    output logic [7:0]       acc_o,
    output logic [7:0]       status_o,
    output logic             prog_mode_o
);
    // ==========================================================
    // storage
    logic [7:0]  fr_q [128];
    logic [13:0] id_q [4];
    logic [12:0] stk_q [STACK_DEPTH];
    logic [13:0] pmem_q [PROG_WORDS];
    logic [7:0]  acc_q, acc_d;
    logic [12:0] pc_q, pc_d;
    logic [2:0]  sp_q, sp_d;
    logic        flush_q, flush_d;
    logic        we;
    logic [6:0]  wa;
    logic [7:0]  wd;
    // ==========================================================
    // pin synchronisers and mode entry
    logic [2:0]  s1_q, s2_q;
    logic        pm_q, pm_d, vpp_prev_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= 3'h0;
            s2_q <= 3'h0;
        end else begin
            s1_q <= {vpp_high_i, prog_clk_pin_i, prog_dat_pin_i};
            s2_q <= s1_q;
        end
    end
    always_comb begin
        pm_d = pm_q;
        if (!s2_q[2]) pm_d = 1'b0;
        else if (!vpp_prev_q && !s2_q[1] && !s2_q[0]) pm_d = 1'b1;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pm_q <= 1'b0;
            vpp_prev_q <= 1'b0;
        end else begin
            pm_q <= pm_d;
            vpp_prev_q <= s2_q[2];
        end
    end
    // ==========================================================
    // serial programming
    logic        ld_p, inc_p;
    logic [13:0] ld_w, rd_w;
    logic [13:0] padr_q, padr_d;
    function automatic logic is_id(input logic [13:0] a);
        return (a >= `MCIS_ID_BASE) && (a <= `MCIS_ID_LAST);
    endfunction : is_id
    assign rd_w = is_id(padr_q) ? id_q[padr_q[1:0]] :
                  (padr_q[13] ? 14'h3FFF : pmem_q[padr_q[9:0]]);
    mcis_serprog u_sp (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .active_i  (pm_q),
        .sclk_i    (s2_q[1]),
        .sdat_i    (s2_q[0]),
        .rd_word_i (rd_w),
        .ld_o      (ld_p),
        .inc_o     (inc_p),
        .ld_word_o (ld_w),
        .dout_o    (prog_dat_o),
        .doe_n_o   (prog_dat_oe_n_o)
    );
    always_comb begin
        padr_d = padr_q;
        if (!pm_q) padr_d = {1'b0, `MCIS_RESET_PC};
        else if (inc_p) padr_d = padr_q + 14'h0001;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) padr_q <= {1'b0, `MCIS_RESET_PC};
        else padr_q <= padr_d;
        // id words reachable only through the serial path
        if (ld_p && is_id(padr_q)) id_q[padr_q[1:0]] <= ld_w;
        else if (ld_p && !padr_q[13]) pmem_q[padr_q[9:0]] <= ld_w;
    end
    // ==========================================================
    // execute
    function automatic logic [7:0] rd_file(input logic [6:0] a, input logic [12:0] pc);
        logic [7:0] v;
        v = fr_q[a];
        if (a == `MCIS_ADR_PCL) v = pc[7:0];
        if (a == `MCIS_ADR_DIR) v[`MCIS_DIR_INBIT] = 1'b1;
        return v;
    endfunction : rd_file
    // six bit opcode field match, shared by the and, register add and clear decode arms
    function automatic logic op6_is(input logic [13:0] ins, input logic [5:0] op);
        return ins[13:8] == op;
    endfunction : op6_is
    logic [7:0] opnd, res, st_new;
    logic [8:0] sum;
    logic [4:0] hsum;
    logic [2:0] bsel;
    logic       setst, dbit;
    always_comb begin
        acc_d = acc_q;
        pc_d = pc_q + 13'h0001;
        sp_d = sp_q;
        flush_d = 1'b0;
        we = 1'b0;
        wa = instr_i[6:0];
        wd = 8'h00;
        res = 8'h00;
        opnd = rd_file(instr_i[6:0], pc_q);
        st_new = fr_q[`MCIS_ADR_STATUS];
        setst = 1'b0;
        dbit = instr_i[7];
        bsel = instr_i[9:7];
        sum = 9'h000;
        hsum = 5'h00;
        if (pm_q) begin
            pc_d = `MCIS_RESET_PC;
            sp_d = 3'h0;
        end else if (flush_q) begin
            // discarded fetch executes as a no-op
        end else if (instr_i[13:9] == 5'(`MCIS_OP6_ADDLIT >> 1)) begin
            sum = {1'b0, acc_q} + {1'b0, instr_i[7:0]};
            hsum = {1'b0, acc_q[3:0]} + {1'b0, instr_i[3:0]};
            acc_d = sum[7:0];
            st_new[`MCIS_ST_C] = sum[8];
            st_new[`MCIS_ST_DC] = hsum[4];
            st_new[`MCIS_ST_Z] = (sum[7:0] == 8'h00);
            setst = 1'b1;
        end else if (op6_is(instr_i, `MCIS_OP6_ANDLIT)) begin
            acc_d = acc_q & instr_i[7:0];
            st_new[`MCIS_ST_Z] = (acc_d == 8'h00);
            setst = 1'b1;
        end else if (op6_is(instr_i, `MCIS_OP6_ADDREG) ||
                     op6_is(instr_i, `MCIS_OP6_ANDREG)) begin
            if (op6_is(instr_i, `MCIS_OP6_ADDREG)) begin
                sum = {1'b0, acc_q} + {1'b0, opnd};
                hsum = {1'b0, acc_q[3:0]} + {1'b0, opnd[3:0]};
                res = sum[7:0];
                st_new[`MCIS_ST_C] = sum[8];
                st_new[`MCIS_ST_DC] = hsum[4];
            end else begin
                res = acc_q & opnd;
            end
            st_new[`MCIS_ST_Z] = (res == 8'h00);
            setst = 1'b1;
            if (dbit) begin
                we = 1'b1;
                wd = res;
            end else begin
                acc_d = res;
            end
        end else if (instr_i == `MCIS_CLR_ACC) begin
            acc_d = 8'h00;
            st_new[`MCIS_ST_Z] = 1'b1;
            setst = 1'b1;
        end else if (op6_is(instr_i, `MCIS_OP6_CLR) && instr_i[7]) begin
            we = 1'b1;
            wd = 8'h00;
            st_new = (instr_i[6:0] == `MCIS_ADR_STATUS) ? 8'h00 : st_new;
            st_new[`MCIS_ST_Z] = 1'b1;
            setst = 1'b1;
        end else if (instr_i[13:10] == `MCIS_OP4_BTSS) begin
            flush_d = opnd[bsel];
        end else if (instr_i[13:11] == `MCIS_OP3_CALL) begin
            sp_d = sp_q + 3'h1;
            pc_d = {fr_q[`MCIS_ADR_PROG_COUNTER_HIGH_LATCH][4:3], instr_i[10:0]};
            flush_d = 1'b1;
        end
        // a written status value loses its flag bits to the flag update
        if (we && wa == `MCIS_ADR_STATUS && setst) begin
            wd[`MCIS_ST_C] = st_new[`MCIS_ST_C];
            wd[`MCIS_ST_DC] = st_new[`MCIS_ST_DC];
            wd[`MCIS_ST_Z] = st_new[`MCIS_ST_Z];
        end
        if (we && wa == `MCIS_ADR_PCL) begin
            pc_d = {fr_q[`MCIS_ADR_PROG_COUNTER_HIGH_LATCH][4:0], wd};
            flush_d = 1'b1;
        end
    end
    // the status view follows whatever lands in the status register this cycle
    logic [7:0] st_view_d;
    always_comb begin
        st_view_d = fr_q[`MCIS_ADR_STATUS];
        if (setst) st_view_d = st_new;
        if (we && wa == `MCIS_ADR_STATUS) st_view_d = wd;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_q <= 8'h00;
            pc_q <= `MCIS_RESET_PC;
            sp_q <= 3'h0;
            flush_q <= 1'b0;
            fr_q[`MCIS_ADR_STATUS] <= 8'h00;
            fr_q[`MCIS_ADR_PROG_COUNTER_HIGH_LATCH] <= 8'h00;
        end else begin
            acc_q <= acc_d;
            pc_q <= pc_d;
            sp_q <= sp_d;
            flush_q <= flush_d;
            if (setst) fr_q[`MCIS_ADR_STATUS] <= st_new;
            if (we) fr_q[wa] <= wd;
            if (sp_d != sp_q && !pm_q) stk_q[sp_q] <= pc_q + 13'h0001;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_o <= `MCIS_RESET_PC;
            acc_o <= 8'h00;
            status_o <= 8'h00;
            prog_mode_o <= 1'b0;
        end else begin
            pc_o <= pc_d;
            acc_o <= acc_d;
            status_o <= st_view_d;
            prog_mode_o <= pm_d;
        end
    end
endmodule : mcis_core

// ==== rtl/mcis_params.svh ====
// constants for the core instruction subset block
`ifndef MCIS_PARAMS_SVH
`define MCIS_PARAMS_SVH
// opcode patterns
`define MCIS_OP6_ADDLIT   6'h3E
`define MCIS_OP6_ANDLIT   6'h39
`define MCIS_OP6_ADDREG   6'h07
`define MCIS_OP6_ANDREG   6'h05
`define MCIS_OP6_CLR      6'h01
`define MCIS_OP4_BTSS     4'h7
`define MCIS_OP3_CALL     3'h4
`define MCIS_CLR_ACC      14'h0103
// file register addresses
`define MCIS_ADR_PCL      7'h02
`define MCIS_ADR_STATUS   7'h03
`define MCIS_ADR_PROG_COUNTER_HIGH_LATCH   7'h0A
`define MCIS_ADR_DIR      7'h05
// status and direction bit positions
`define MCIS_ST_C         0
`define MCIS_ST_DC        1
`define MCIS_ST_Z         2
`define MCIS_DIR_INBIT    3
// program mode framing
`define MCIS_CMD_BITS     6
`define MCIS_DATA_BITS    14
`define MCIS_CMD_LOAD     6'h02
`define MCIS_CMD_READ     6'h04
`define MCIS_CMD_INCADR   6'h06
`define MCIS_ID_BASE      14'h2000
`define MCIS_ID_LAST      14'h2003
`define MCIS_CFG_ADR      14'h2000
`define MCIS_RESET_PC     13'h0000
`endif

// ==== rtl/mcis_pkg.sv ====
// types for the core instruction subset block
`include "mcis_params.svh"
package mcis_pkg;
    typedef enum logic [1:0] {
        MCIS_SP_CMD  = 2'b00,
        MCIS_SP_DATA = 2'b01,
        MCIS_SP_EXEC = 2'b11
    } mcis_sp_state_t;
endpackage : mcis_pkg

// ==== rtl/mcis_serprog.sv ====
// serial program/verify command and data shifter
`include "mcis_params.svh"
module mcis_serprog
    import mcis_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // synchronised programming pins
    input  wire logic        active_i,
    input  wire logic        sclk_i,
    input  wire logic        sdat_i,
    // word interface
    input  wire logic [13:0] rd_word_i,
    output logic             ld_o,
    output logic             inc_o,
    output logic [13:0]      ld_word_o,
    output logic             dout_o,
    output logic             doe_n_o
);
    // ==========================================================
    // shifter
    mcis_sp_state_t      st_q, st_d;
    logic [4:0]          cnt_q, cnt_d;
    logic [5:0]          cmd_q, cmd_d;
    logic [13:0]         sh_q, sh_d;
    logic                ck_q, ld_d, inc_d, dout_d, doe_d;
    logic                rise;
    assign rise = sclk_i & ~ck_q;
    always_comb begin
        st_d = st_q; cnt_d = cnt_q; cmd_d = cmd_q; sh_d = sh_q;
        ld_d = 1'b0; inc_d = 1'b0; dout_d = dout_o; doe_d = doe_n_o;
        if (!active_i) begin
            st_d = MCIS_SP_CMD; cnt_d = 5'h00; doe_d = 1'b1;
        end else if (rise) begin
            case (st_q)
                MCIS_SP_CMD: begin
                    cmd_d = {sdat_i, cmd_q[5:1]};
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == 5'(`MCIS_CMD_BITS - 1)) begin
                        cnt_d = 5'h00;
                        if (cmd_d == `MCIS_CMD_LOAD) st_d = MCIS_SP_DATA;
                        else if (cmd_d == `MCIS_CMD_READ) begin
                            st_d = MCIS_SP_EXEC; sh_d = rd_word_i;
                            doe_d = 1'b0; dout_d = rd_word_i[0];
                        end else if (cmd_d == `MCIS_CMD_INCADR) inc_d = 1'b1;
                    end
                end
                MCIS_SP_DATA: begin
                    sh_d = {sdat_i, sh_q[13:1]};
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == 5'(`MCIS_DATA_BITS - 1)) begin
                        st_d = MCIS_SP_CMD; cnt_d = 5'h00; ld_d = 1'b1;
                    end
                end
                MCIS_SP_EXEC: begin
                    sh_d = {1'b0, sh_q[13:1]};
                    dout_d = sh_d[0];
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == 5'(`MCIS_DATA_BITS - 1)) begin
                        st_d = MCIS_SP_CMD; cnt_d = 5'h00; doe_d = 1'b1;
                    end
                end
                default: st_d = MCIS_SP_CMD;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= MCIS_SP_CMD; cnt_q <= 5'h00; cmd_q <= 6'h00; sh_q <= 14'h0000;
            ck_q <= 1'b0; ld_o <= 1'b0; inc_o <= 1'b0; dout_o <= 1'b0; doe_n_o <= 1'b1;
        end else begin
            st_q <= st_d; cnt_q <= cnt_d; cmd_q <= cmd_d; sh_q <= sh_d;
            ck_q <= sclk_i; ld_o <= ld_d; inc_o <= inc_d; dout_o <= dout_d;
            doe_n_o <= doe_d;
        end
    end
    assign ld_word_o = sh_q;
endmodule : mcis_serprog
